// ===== pmcd_pkg.sv
// Constants, register map and state type of the power mode and clock divider block
package pmcd_pkg;
    localparam int NPIN = 9;
    localparam int NGRP = 4;
    localparam int NPER = 8;
    localparam int INT_W = 5;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PCONP = 8'h04;
    localparam logic [7:0] OFF_DIV = 8'h08;
    localparam logic [7:0] OFF_MAP = 8'h0c;
    localparam logic [7:0] OFF_EXTMODE = 8'h10;
    localparam logic [7:0] OFF_WAKE = 8'h14;
    localparam logic [7:0] OFF_INT_STAT = 8'h18;
    localparam logic [7:0] OFF_INT_MASK = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam int CTRL_IDLE = 0;
    localparam int CTRL_PDOWN = 1;
    localparam int INT_WAKE = 4;
    localparam logic [1:0] DIV_QUARTER = 2'h0;
    localparam logic [1:0] DIV_FULL = 2'h1;
    localparam logic [1:0] DIV_HALF = 2'h2;
    localparam logic [1:0] DIV_LAST_QUARTER = 2'h3;
    localparam logic [NPER-1:0] PCONP_RST = 8'hff;
    localparam logic [15:0] WAKE_CYCLES_DEF = 16'h1000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {ST_RESET, ST_RUN, ST_IDLE, ST_PDOWN, ST_WAKE} pmcd_state_t;
endpackage : pmcd_pkg

// ===== pmcd_top.sv
// Power modes, wake-up timer, external wake inputs, vector remap and peripheral clock divider
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [RL1] Execution starts only after the wake-up timer sees a good oscillator.
// [RL2] Nine edge or level external inputs fold into four interrupt lines.
// [RL3] Enabled external input groups wake the chip from power-down.
// [RL4] Vector area at address zero maps to flash or SRAM by a bit.
// [RL5] Idle stops the core until reset or interrupt.
// [RL6] Peripheral clock keeps running in idle; peripheral interrupt resumes the core.
// [RL7] Power-down stops the oscillator and gates every internal clock.
// [RL8] Power-down holds all register contents and freezes output pins.
// [RL9] Power-down ends only by reset or a clockless external interrupt.
// [RL10] Each peripheral has its own power-off bit.
// [RL11] Peripheral clock is processor clock divided by one, two or four.
// [RL12] Divider resets to one quarter rate.
// [RL13] PLL stays enabled through idle if it was requested.
// [RL14] Any reset restarts the timer; core reset holds until all conditions met.
// [RL15] Every power-down wake passes through the wake-up timer delay.
// [RL16] Idle and power-down requests clear themselves on mode exit.
// [RL17] Software sets the divider and lets it settle before timed accesses.
module pmcd_top #(
    parameter logic [15:0] WAKE_CYCLES = pmcd_pkg::WAKE_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ext_reset_n,
    input wire logic wdt_reset,
    input wire logic osc_good,
    input wire logic flash_init_done,
    input wire logic pll_req,
    input wire logic periph_irq,
    input wire logic [pmcd_pkg::NPIN-1:0] ext_pin,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic core_reset_n,
    output logic cpu_run,
    output logic osc_enable,
    output logic clocks_on,
    output logic hold_pins,
    output logic pclk_en,
    output logic pll_enable,
    output logic vec_sram,
    output logic irq,
    output logic [pmcd_pkg::NPER-1:0] periph_on,
    output logic [pmcd_pkg::NGRP-1:0] ext_irq
);
    import pmcd_pkg::*;

    pmcd_state_t state, next_state;
    logic [1:0] ctrl, div_sel, div_cnt;
    logic [NPER-1:0] pconp;
    logic map_sram;
    logic [NPIN-1:0] ext_mode, pin_q;
    logic [NGRP-1:0] wake_en, grp_evt;
    logic [INT_W-1:0] int_stat, int_mask;
    logic [15:0] wt_cnt;
    logic aw_full, w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Chip reset sources: pin and watchdog
    wire chip_rst = !ext_reset_n | wdt_reset;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire do_wr = aw_full & w_full & !s_axi_bvalid;
    wire next_aw_full = (aw_full & !do_wr) | aw_take;
    wire next_w_full = (w_full & !do_wr) | w_take;
    wire next_rvalid = (s_axi_rvalid & !s_axi_rready) | ar_take;
    // Core is frozen in power-down, so nothing it could write lands
    wire wr_en = do_wr & (state != ST_PDOWN) & !chip_rst; // RL8
    wire lane0 = w_strb[0];
    wire wr_ctrl = wr_en & lane0 & (aw_addr == OFF_CTRL);
    wire wr_pconp = wr_en & lane0 & (aw_addr == OFF_PCONP);
    wire wr_div = wr_en & lane0 & (aw_addr == OFF_DIV);
    wire wr_map = wr_en & lane0 & (aw_addr == OFF_MAP);
    wire wr_mode_lo = wr_en & lane0 & (aw_addr == OFF_EXTMODE);
    wire wr_mode_hi = wr_en & w_strb[1] & (aw_addr == OFF_EXTMODE);
    wire wr_wake = wr_en & lane0 & (aw_addr == OFF_WAKE);
    wire wr_mask = wr_en & lane0 & (aw_addr == OFF_INT_MASK);
    wire wr_hit = (aw_addr <= OFF_INT_MASK) & (aw_addr[1:0] == 2'h0)
        & (aw_addr != OFF_INT_STAT);
    wire rd_hit = (s_axi_araddr <= OFF_STATUS) & (s_axi_araddr[1:0] == 2'h0);
    wire rd_clear = ar_take & (s_axi_araddr == OFF_INT_STAT);
    wire [31:0] rd_data =
        (s_axi_araddr == OFF_CTRL) ? {30'h0, ctrl} :
        (s_axi_araddr == OFF_PCONP) ? {24'h0, pconp} :
        (s_axi_araddr == OFF_DIV) ? {30'h0, div_sel} :
        (s_axi_araddr == OFF_MAP) ? {31'h0, map_sram} :
        (s_axi_araddr == OFF_EXTMODE) ? {23'h0, ext_mode} :
        (s_axi_araddr == OFF_WAKE) ? {28'h0, wake_en} :
        (s_axi_araddr == OFF_INT_STAT) ? {27'h0, int_stat} :
        (s_axi_araddr == OFF_INT_MASK) ? {27'h0, int_mask} :
        (s_axi_araddr == OFF_STATUS) ? {28'h0, osc_good, state} : 32'h0;

    // Mode bit 1 = edge (rising), 0 = level (high); level needs no clock to be seen
    wire [NPIN-1:0] pin_evt = (ext_mode & ext_pin & ~pin_q) | (~ext_mode & ext_pin);
    always_comb begin
        grp_evt = '0;
        for (int i = 0; i < NPIN; i++) begin
            grp_evt[i % NGRP] = grp_evt[i % NGRP] | pin_evt[i]; // RL2
        end
    end
    wire pd_wake = |(grp_evt & wake_en); // RL3 RL9
    wire idle_wake = periph_irq | (|grp_evt) | irq; // RL6
    wire wt_done = wt_cnt == WAKE_CYCLES - 16'h1;

    always_comb begin
        next_state = state;
        case (state)
            ST_RESET: begin
                if (osc_good && wt_done && flash_init_done) begin
                    next_state = ST_RUN; // RL1 RL14
                end
            end
            ST_RUN: begin
                if (ctrl[CTRL_PDOWN]) begin
                    next_state = ST_PDOWN; // RL7
                end else if (ctrl[CTRL_IDLE]) begin
                    next_state = ST_IDLE; // RL5
                end
            end
            ST_IDLE: begin
                if (idle_wake) begin
                    next_state = ST_RUN; // RL5
                end
            end
            ST_PDOWN: begin
                if (pd_wake) begin
                    next_state = ST_WAKE; // RL3
                end
            end
            ST_WAKE: begin
                if (osc_good && wt_done) begin
                    next_state = ST_RUN; // RL15
                end
            end
            default: next_state = ST_RESET;
        endcase
    end

    wire pmcd_state_t st_n = chip_rst ? ST_RESET : next_state; // RL14
    wire wake_done = (state == ST_WAKE) & (st_n == ST_RUN);
    wire mode_exit = ((state == ST_IDLE) & (st_n == ST_RUN)) | wake_done; // RL16
    wire live_n = (st_n == ST_RUN) | (st_n == ST_IDLE); // RL6 RL7
    wire div_tick = (div_sel == DIV_FULL) | ((div_sel == DIV_HALF) & div_cnt[0])
        | ((div_sel == DIV_QUARTER || div_sel == DIV_LAST_QUARTER) & (div_cnt == 2'h3));
    wire [INT_W-1:0] int_evt = {wake_done, grp_evt};
    wire counting = (state == ST_RESET) | (state == ST_WAKE);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_RESET;
            wt_cnt <= 16'h0;
        end else begin
            state <= st_n;
            // Oscillator loss restarts the wait: stability must be continuous
            if (chip_rst || !counting || !osc_good) begin
                wt_cnt <= 16'h0; // RL1 RL14
            end else if (!wt_done) begin
                wt_cnt <= wt_cnt + 16'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= 2'h0;
            pconp <= PCONP_RST;
            div_sel <= DIV_QUARTER;
            map_sram <= 1'b0;
            ext_mode <= '0;
            wake_en <= '0;
            int_mask <= '0;
        end else if (chip_rst) begin
            ctrl <= 2'h0;
            pconp <= PCONP_RST;
            div_sel <= DIV_QUARTER; // RL12
            map_sram <= 1'b0;
            ext_mode <= '0;
            wake_en <= '0;
            int_mask <= '0;
        end else begin
            if (mode_exit) begin
                ctrl <= 2'h0; // RL16
            end else if (wr_ctrl) begin
                ctrl <= w_data[1:0];
            end
            if (wr_pconp) begin
                pconp <= w_data[NPER-1:0]; // RL10
            end
            if (wr_div) begin
                div_sel <= w_data[1:0]; // RL11
            end
            if (wr_map) begin
                map_sram <= w_data[0]; // RL4
            end
            if (wr_mode_lo) begin
                ext_mode[7:0] <= w_data[7:0];
            end
            if (wr_mode_hi) begin
                ext_mode[8] <= w_data[8];
            end
            if (wr_wake) begin
                wake_en <= w_data[NGRP-1:0];
            end
            if (wr_mask) begin
                int_mask <= w_data[INT_W-1:0];
            end
        end
    end

    // Sticky status: a new event wins over the read that clears
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_stat <= '0;
        end else if (chip_rst) begin
            int_stat <= '0;
        end else begin
            int_stat <= (rd_clear ? '0 : int_stat) | int_evt;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_reset_n <= 1'b0;
            cpu_run <= 1'b0;
            osc_enable <= 1'b1;
            clocks_on <= 1'b0;
            hold_pins <= 1'b0;
            pll_enable <= 1'b0;
            pclk_en <= 1'b0;
            div_cnt <= 2'h0;
            periph_on <= '0;
            vec_sram <= 1'b0;
            ext_irq <= '0;
            irq <= 1'b0;
            pin_q <= '0;
        end else begin
            core_reset_n <= st_n != ST_RESET; // RL14
            cpu_run <= st_n == ST_RUN; // RL5
            osc_enable <= st_n != ST_PDOWN; // RL7
            clocks_on <= live_n; // RL7
            hold_pins <= (st_n == ST_PDOWN) | (st_n == ST_WAKE); // RL8
            pll_enable <= pll_req & live_n; // RL13
            pclk_en <= live_n & div_tick; // RL6 RL11
            div_cnt <= live_n ? div_cnt + 2'h1 : 2'h0;
            periph_on <= pconp & {NPER{live_n}}; // RL10
            vec_sram <= map_sram; // RL4
            ext_irq <= grp_evt; // RL2
            irq <= |(int_stat & int_mask);
            pin_q <= ext_pin;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_awready <= !next_aw_full;
            s_axi_wready <= !next_w_full;
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_OSC_BEFORE_RUN: assert property ( // RL1
        (state == ST_RUN && $past(state) == ST_RESET) |-> $past(osc_good) && $past(wt_done))
        else $error("core released without stable oscillator");
    AST_GROUP_IRQ: assert property ( // RL2
        grp_evt[1] |=> ext_irq[1])
        else $error("external group event not forwarded");
    AST_PD_WAKE: assert property ( // RL3
        (state == ST_PDOWN && pd_wake && !chip_rst) |=> state == ST_WAKE)
        else $error("enabled external input did not wake power-down");
    AST_REMAP: assert property ( // RL4
        wr_map ##1 !chip_rst |=> vec_sram == $past(w_data[0], 2))
        else $error("vector remap did not follow write");
    AST_IDLE_STOP: assert property ( // RL5
        (state == ST_IDLE && !idle_wake) |=> !cpu_run)
        else $error("core ran during idle");
    AST_IDLE_PCLK: assert property ( // RL6
        (state == ST_IDLE && div_sel == DIV_FULL && !chip_rst) |=> pclk_en)
        else $error("peripheral clock stopped in idle");
    AST_PD_CLOCKS: assert property ( // RL7
        (state == ST_PDOWN && !pd_wake && !chip_rst) |=> !osc_enable && !pclk_en && !clocks_on)
        else $error("clocks running in power-down");
    AST_PD_HOLD: assert property ( // RL8
        (state == ST_PDOWN && $past(state) == ST_PDOWN) |-> $stable(pconp) && hold_pins)
        else $error("state changed during power-down");
    AST_PD_EXIT: assert property ( // RL9
        (state == ST_PDOWN && !pd_wake && !chip_rst) |=> state == ST_PDOWN)
        else $error("power-down left without wake source");
    AST_PERIPH_OFF: assert property ( // RL10
        periph_on[0] |-> $past(pconp[0]))
        else $error("peripheral powered while switched off");
    AST_DIV_RESET: assert property ( // RL12
        (state == ST_RESET && $past(state) == ST_RESET) |-> div_sel == DIV_QUARTER)
        else $error("divider not quarter rate in reset");
    AST_RESET_HOLD: assert property ( // RL14
        chip_rst |=> !core_reset_n ##1 !core_reset_n)
        else $error("core reset released too early");
    AST_WAKE_DELAY: assert property ( // RL15
        (state == ST_RUN && $past(state) == ST_WAKE) |-> $past(wt_cnt) == WAKE_CYCLES - 16'h1)
        else $error("wake skipped the timer delay");
    AST_REQ_CLEAR: assert property ( // RL16
        (state == ST_RUN && $past(state) == ST_IDLE) |-> ctrl == 2'h0)
        else $error("mode request not cleared on exit");

    COV_IDLE_WAKE: cover property (state == ST_IDLE ##1 state == ST_RUN);
    COV_PD_WAKE: cover property (state == ST_WAKE ##1 state == ST_RUN);
    COV_READ_CLEAR: cover property (rd_clear && int_stat != '0);
endmodule : pmcd_top
`default_nettype wire

// ===== pmcd_partner.sv
// Oscillator, flash controller and external pin sources facing the block
`timescale 1ns/10ps
`default_nettype none
module pmcd_partner #(
    parameter int OSC_START = 3
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic osc_enable,
    input wire logic [pmcd_pkg::NPIN-1:0] pin_req,
    output logic osc_good,
    output logic flash_init_done,
    output logic [pmcd_pkg::NPIN-1:0] ext_pin
);
    import pmcd_pkg::*;
    int osc_cnt;
    // Amplitude builds up only while enabled, so good drops at once on stop
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_cnt <= 0;
            flash_init_done <= 1'b0;
            ext_pin <= '0;
        end else begin
            osc_cnt <= !osc_enable ? 0 : (osc_cnt < OSC_START) ? osc_cnt + 1 : osc_cnt;
            flash_init_done <= 1'b1;
            ext_pin <= pin_req;
        end
    end
    assign osc_good = osc_enable && (osc_cnt >= OSC_START);
endmodule : pmcd_partner
`default_nettype wire

// ===== pmcd_top_bench.sv
// Self-checking bench of the power mode and clock divider block
`timescale 1ns/10ps
`default_nettype none
`define PMCD_CHK(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module pmcd_top_bench;
    import pmcd_pkg::*;
    localparam int WC = 8;
    logic ref_clk = 1'b0, reset_n = 1'b0, ext_reset_n = 1'b1, wdt_reset = 1'b0;
    logic pll_req = 1'b0, periph_irq = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [NPIN-1:0] pin_req = '0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic osc_good, flash_init_done, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, core_reset_n, cpu_run, osc_enable, clocks_on, hold_pins, pclk_en;
    logic pll_enable, vec_sram, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic [NPER-1:0] periph_on;
    logic [NGRP-1:0] ext_irq;
    logic [NPIN-1:0] ext_pin;
    int err_count = 0, checks = 0, cycle_count = 0, n;
    always #4 ref_clk = ~ref_clk;
    pmcd_partner partner (.ref_clk(ref_clk), .reset_n(reset_n), .osc_enable(osc_enable),
        .pin_req(pin_req), .osc_good(osc_good), .flash_init_done(flash_init_done),
        .ext_pin(ext_pin));
    pmcd_top #(.WAKE_CYCLES(16'(WC))) uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .ext_reset_n(ext_reset_n), .wdt_reset(wdt_reset), .osc_good(osc_good),
        .flash_init_done(flash_init_done), .pll_req(pll_req), .periph_irq(periph_irq),
        .ext_pin(ext_pin), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .core_reset_n(core_reset_n), .cpu_run(cpu_run), .osc_enable(osc_enable),
        .clocks_on(clocks_on), .hold_pins(hold_pins), .pclk_en(pclk_en),
        .pll_enable(pll_enable), .vec_sram(vec_sram), .irq(irq), .periph_on(periph_on),
        .ext_irq(ext_irq));
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask : cyc
    // Response ready lines stay high, so a back-to-back call never drives them twice
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        dat = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd
    task automatic period(output int p);
        p = 0;
        do @(posedge ref_clk); while (pclk_en !== 1'b1);
        do begin
            @(posedge ref_clk);
            p++;
        end while (pclk_en !== 1'b1 && p < 10);
    endtask : period
    task automatic t_reset(input int min_wait);
        n = 0;
        while (core_reset_n !== 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
        `PMCD_CHK(n >= min_wait, 1'b1);
        cyc(2);
        `PMCD_CHK(cpu_run, 1'b1);
        rd(OFF_STATUS, d, r);
        `PMCD_CHK(d, 32'h9);
        rd(OFF_DIV, d, r);
        `PMCD_CHK({d, r}, {32'h0, RESP_OKAY});
        period(n);
        `PMCD_CHK(n, 4);
        `PMCD_CHK(periph_on, PCONP_RST);
    endtask : t_reset
    task automatic t_div;
        logic [1:0] codes[4] = '{DIV_FULL, DIV_HALF, DIV_LAST_QUARTER, DIV_QUARTER};
        int per[4] = '{1, 2, 4, 4};
        foreach (codes[i]) begin
            wr(OFF_DIV, {30'h0, codes[i]}, r);
            cyc(8);
            period(n);
            `PMCD_CHK(n, per[i]);
        end
    endtask : t_div
    task automatic t_regs;
        wr(OFF_PCONP, 32'h5a, r);
        wr(OFF_MAP, 32'h1, r);
        `PMCD_CHK(r, RESP_OKAY);
        cyc(3);
        `PMCD_CHK({periph_on, vec_sram}, {8'h5a, 1'b1});
        wr(8'h40, 32'h0, r);
        `PMCD_CHK(r, RESP_SLVERR);
        wr(OFF_MAP, 32'h0, r);
        cyc(3);
        `PMCD_CHK(vec_sram, 1'b0);
        rd(8'h44, d, r);
        `PMCD_CHK({d, r}, {32'h0, RESP_SLVERR});
    endtask : t_regs
    task automatic t_ext;
        wr(OFF_EXTMODE, 32'h0, r);
        wr(OFF_INT_MASK, 32'h1f, r);
        for (int i = 0; i < NPIN; i++) begin
            pin_req <= NPIN'(1) << i;
            cyc(6);
            `PMCD_CHK({ext_irq, irq}, {NGRP'(1) << (i % NGRP), 1'b1});
            pin_req <= '0;
            cyc(3);
            rd(OFF_INT_STAT, d, r);
            `PMCD_CHK(d, 32'h1 << (i % NGRP));
            cyc(3);
            `PMCD_CHK(irq, 1'b0);
        end
        wr(OFF_INT_MASK, 32'h0, r);
        pin_req <= 9'h002;
        cyc(6);
        `PMCD_CHK(irq, 1'b0);
        wr(OFF_INT_MASK, 32'h1f, r);
        cyc(3);
        `PMCD_CHK(irq, 1'b1);
        pin_req <= '0;
        wr(OFF_EXTMODE, 32'h2, r);
        rd(OFF_INT_STAT, d, r);
        n = 0;
        pin_req <= 9'h002;
        repeat (8) begin
            @(posedge ref_clk);
            n += int'(ext_irq[1] === 1'b1);
        end
        `PMCD_CHK(n, 1);
        pin_req <= '0;
        wr(OFF_EXTMODE, 32'h0, r);
        rd(OFF_INT_STAT, d, r);
    endtask : t_ext
    task automatic t_idle;
        pll_req <= 1'b1;
        // Full rate here so the later chip reset must really restore quarter rate
        wr(OFF_DIV, {30'h0, DIV_FULL}, r);
        wr(OFF_CTRL, 32'h1, r);
        cyc(3);
        `PMCD_CHK({cpu_run, clocks_on}, 2'b01);
        `PMCD_CHK(pll_enable, 1'b1);
        period(n);
        `PMCD_CHK(n, 1);
        periph_irq <= 1'b1;
        cyc(3);
        periph_irq <= 1'b0;
        `PMCD_CHK(cpu_run, 1'b1);
        rd(OFF_CTRL, d, r);
        `PMCD_CHK(d, 32'h0);
    endtask : t_idle
    task automatic t_pdown;
        wr(OFF_WAKE, 32'h1, r);
        wr(OFF_INT_MASK, 32'h10, r);
        wr(OFF_CTRL, 32'h2, r);
        cyc(3);
        `PMCD_CHK({osc_enable, clocks_on, pclk_en, pll_enable, periph_on}, 12'h0);
        `PMCD_CHK({hold_pins, cpu_run}, 2'b10);
        wr(OFF_PCONP, 32'h0, r);
        // Group one is not wake-enabled and must leave the chip asleep
        pin_req <= 9'h002;
        cyc(8);
        `PMCD_CHK(osc_enable, 1'b0);
        pin_req <= 9'h001;
        while (osc_enable !== 1'b1) @(posedge ref_clk);
        `PMCD_CHK(hold_pins, 1'b1);
        n = 0;
        while (cpu_run !== 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
        `PMCD_CHK(n >= WC, 1'b1);
        pin_req <= '0;
        cyc(2);
        `PMCD_CHK(irq, 1'b1);
        rd(OFF_INT_STAT, d, r);
        `PMCD_CHK(d[INT_WAKE], 1'b1);
        `PMCD_CHK(periph_on, 8'h5a);
        rd(OFF_CTRL, d, r);
        `PMCD_CHK(d, 32'h0);
    endtask : t_pdown
    task conclude;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // Whole run needs a few hundred cycles; the ceiling leaves wide margin
    always @(posedge ref_clk) begin
        cycle_count++;
        if (cycle_count == 20000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset(WC);
        t_div();
        t_regs();
        t_ext();
        t_idle();
        t_pdown();
        wdt_reset <= 1'b1;
        cyc(3);
        `PMCD_CHK(core_reset_n, 1'b0);
        wdt_reset <= 1'b0;
        t_reset(WC - 4);
        conclude();
    end
endmodule : pmcd_top_bench
`default_nettype wire
